// ==== bench/line_interface_tx_control_tb_top.sv ====
// Self-checking bench for the line interface transmit control block
`timescale 1ns/10ps
module line_interface_tx_control_tb_top import litx_pkg::*; ;
	logic       core_clk, rst_b, reg_wr, reg_rd;
	logic       transmit_clock, jitter_clock, tx_data;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic       tx_line_pos, tx_line_neg, tx_line_oe, tx_line_open_drain;
	logic       agc_enable, e1_mode, cur_limit_en, ja_clk_from_pll;
	logic       line_reset_pulse, viol_sent;
	logic [5:0] gain_level;
	logic [2:0] build_out_code;
	int         bad_count, checked, cyc, viol_cnt, lrst_cnt;

	litx_top litx_top_inst (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.transmit_clock(transmit_clock), .jitter_clock(jitter_clock), .tx_data(tx_data),
		.tx_line_pos(tx_line_pos), .tx_line_neg(tx_line_neg), .tx_line_oe(tx_line_oe),
		.tx_line_open_drain(tx_line_open_drain), .agc_enable(agc_enable),
		.gain_level(gain_level), .build_out_code(build_out_code), .e1_mode(e1_mode),
		.cur_limit_en(cur_limit_en), .ja_clk_from_pll(ja_clk_from_pll),
		.line_reset_pulse(line_reset_pulse), .viol_sent(viol_sent));

	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Pulse counters and hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (viol_sent === 1'b1) viol_cnt++;
		if (line_reset_pulse === 1'b1) lrst_cnt++;
		if (cyc == 6000) begin
			bad_count++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp, msg);
	endtask

	task automatic settle();
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	// One bit slot on either pin, long enough to cross the synchroniser
	task automatic slot(input bit jit);
		@(posedge core_clk);
		if (jit) jitter_clock <= 1'b1;
		else transmit_clock <= 1'b1;
		repeat (4) @(posedge core_clk);
		jitter_clock <= 1'b0;
		transmit_clock <= 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [7:0] offs [4];
		offs = '{LITX_OFF_CTRL_ONE, LITX_OFF_CTRL_TWO, LITX_OFF_CTRL_THREE, LITX_OFF_GAIN};
		chk({7'h00, agc_enable}, 8'h01, "agc at reset");
		chk({7'h00, cur_limit_en}, 8'h01, "limiter at reset");
		chk({2'h0, gain_level}, 8'h00, "gain at reset");
		for (int i = 0; i < 4; i++) rd_chk(offs[i], LITX_RST_VAL, "reset value");
		$display("test reset done");
	endtask

	task automatic t_gain();
		wr(LITX_OFF_GAIN, 8'h45);
		settle();
		chk({7'h00, agc_enable}, 8'h00, "agc off");
		chk({2'h0, gain_level}, 8'h05, "manual gain");
		rd_chk(LITX_OFF_GAIN, 8'h45, "gain readback");
		wr(LITX_OFF_GAIN, 8'h3f);
		settle();
		chk({7'h00, agc_enable}, 8'h01, "agc on");
		chk({2'h0, gain_level}, 8'h00, "gain ignored");
		// Recommended code for T1, no impedance match, build-out 0, bit 7 kept zero
		wr(LITX_OFF_GAIN, 8'h66);
		settle();
		chk({2'h0, gain_level}, 8'h26, "recommended gain");
		wr(LITX_OFF_GAIN, 8'h00);
		$display("test gain done");
	endtask

	task automatic t_ctrl();
		wr(LITX_OFF_CTRL_ONE, 8'ha0);
		wr(8'h7c, 8'hff);
		settle();
		chk({5'h00, build_out_code}, 8'h05, "build-out code");
		rd_chk(LITX_OFF_CTRL_ONE, 8'ha0, "ctrl one readback");
		rd_chk(8'h7c, 8'h00, "unmapped read");
		wr(LITX_OFF_CTRL_TWO, 8'h8b);
		settle();
		chk({7'h00, tx_line_oe}, 8'h01, "line driven");
		chk({7'h00, e1_mode}, 8'h01, "e1 select");
		chk({7'h00, cur_limit_en}, 8'h00, "limiter off");
		chk({7'h00, ja_clk_from_pll}, 8'h01, "pll source");
		chk({7'h00, tx_line_open_drain}, 8'h01, "open drain");
		rd_chk(LITX_OFF_CTRL_TWO, 8'h8b, "ctrl two readback");
		wr(LITX_OFF_CTRL_ONE, 8'h00);
		settle();
		chk({7'h00, tx_line_open_drain}, 8'h00, "push-pull at code 0");
		wr(LITX_OFF_CTRL_TWO, 8'h00);
		settle();
		chk({7'h00, e1_mode}, 8'h00, "t1 select");
		chk({7'h00, cur_limit_en}, 8'h01, "limiter on");
		chk({7'h00, ja_clk_from_pll}, 8'h00, "master source");
		// Shape and termination registers live outside this block
		wr(8'hf1, 8'h00);
		wr(8'hf2, 8'h00);
		wr(8'h7b, 8'h00);
		rd_chk(8'hf1, 8'h00, "shape register not mapped");
		rd_chk(8'h7b, 8'h00, "termination register not mapped");
		$display("test ctrl done");
	endtask

	task automatic t_lrst();
		int n;
		n = lrst_cnt;
		wr(LITX_OFF_CTRL_TWO, 8'h40);
		wr(LITX_OFF_CTRL_TWO, 8'h40);
		settle();
		chk(8'(lrst_cnt - n), 8'h01, "one reset per rise");
		wr(LITX_OFF_CTRL_TWO, 8'h00);
		wr(LITX_OFF_CTRL_TWO, 8'h40);
		settle();
		chk(8'(lrst_cnt - n), 8'h02, "reset after re-arm");
		wr(LITX_OFF_CTRL_TWO, 8'h00);
		$display("test line reset done");
	endtask

	task automatic t_ones();
		logic [1:0] cur, prev;
		tx_data <= 1'b0;
		slot(1'b1);
		prev = {tx_line_pos, tx_line_neg};
		chk({6'h00, prev ^ {prev[0], prev[1]}}, 8'h03, "first mark");
		for (int i = 0; i < 4; i++) begin
			slot(1'b1);
			cur = {tx_line_pos, tx_line_neg};
			chk({6'h00, cur}, {6'h00, prev[0], prev[1]}, "all ones mark");
			prev = cur;
		end
		$display("test all ones done");
	endtask

	task automatic t_alt();
		logic prev;
		wr(LITX_OFF_CTRL_THREE, 8'h01);
		wr(LITX_OFF_CTRL_TWO, 8'h10);
		slot(1'b0);
		prev = tx_line_pos | tx_line_neg;
		for (int i = 0; i < 4; i++) begin
			slot(1'b0);
			chk({7'h00, tx_line_pos | tx_line_neg}, {7'h00, !prev}, "alternating");
			prev = tx_line_pos | tx_line_neg;
		end
		wr(LITX_OFF_CTRL_THREE, 8'h00);
		$display("test alternating done");
	endtask

	task automatic t_viol();
		int n;
		tx_data <= 1'b1;
		n = viol_cnt;
		repeat (4) slot(1'b0);
		chk(8'(viol_cnt - n), 8'h00, "no violation unarmed");
		wr(LITX_OFF_CTRL_TWO, 8'h30);
		repeat (6) slot(1'b0);
		chk(8'(viol_cnt - n), 8'h01, "single violation");
		repeat (6) slot(1'b0);
		chk(8'(viol_cnt - n), 8'h01, "no repeat");
		wr(LITX_OFF_CTRL_TWO, 8'h10);
		wr(LITX_OFF_CTRL_TWO, 8'h30);
		repeat (6) slot(1'b0);
		chk(8'(viol_cnt - n), 8'h02, "violation after re-arm");
		$display("test violation done");
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		transmit_clock = 1'b0;
		jitter_clock = 1'b0;
		tx_data = 1'b0;
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		#1;
		t_reset();
		t_gain();
		t_ctrl();
		t_lrst();
		t_ones();
		t_alt();
		t_viol();
		wrap_up();
	end
endmodule // line_interface_tx_control_tb_top

// ==== core/litx_cfg_if.sv ====
// Interface carrying decoded control from register bank to line driver logic
`timescale 1ns/10ps
interface litx_cfg_if;
	logic       agc_off;
	logic [5:0] gain_code;
	logic [2:0] build_out_code;
	logic       custom_driver_select;
	logic       tx_data_enable;
	logic       alternating_pattern;
	logic       viol_req;
	modport src (output agc_off, gain_code, build_out_code, custom_driver_select,
		tx_data_enable, alternating_pattern, viol_req);
	modport dst (input agc_off, gain_code, build_out_code, custom_driver_select,
		tx_data_enable, alternating_pattern, viol_req);
endinterface // litx_cfg_if

// ==== core/litx_line_driver.sv ====
// Transmit symbol selection: all ones, alternating, data, violation insertion
`timescale 1ns/10ps
module litx_line_driver import litx_pkg::*; (
	input  wire logic core_clk,     // Clock
	input  wire logic rst_b,        // Reset, active low
	litx_cfg_if.dst   cfg,          // Decoded control
	input  wire logic bit_tick,     // One line bit slot
	input  wire logic ja_tick,      // Jitter clock bit slot
	input  wire logic tx_data,      // Data bit to send
	output logic      tx_line_pos,  // Positive pulse
	output logic      tx_line_neg,  // Negative pulse
	output logic      line_oe,      // Drive enable
	output logic      viol_done     // Violation sent pulse
);
	litx_viol_e state_q;
	logic [1:0] ones_q;
	logic       last_pol_q;
	logic       alt_q;
	logic       mark;
	logic       use_viol;
	logic       tick;
	logic       sq_mode;

	assign tick     = cfg.tx_data_enable ? bit_tick : ja_tick; // R12
	assign mark     = !cfg.tx_data_enable ? 1'b1 : // R12
	                  cfg.alternating_pattern ? alt_q : tx_data; // R16
	assign use_viol = (state_q == LITX_TX_ARMED) && mark &&
	                  (ones_q == 2'(LITX_ONES_RUN - 1)); // R13
	assign sq_mode  = cfg.custom_driver_select && (cfg.build_out_code == LITX_LBO_SHORT); // R09

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= LITX_TX_IDLE;
		end else if (cfg.viol_req) begin
			state_q <= LITX_TX_ARMED; // R13
		end else if (tick && use_viol) begin
			state_q <= LITX_TX_IDLE; // R13
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ones_q <= 2'h0;
			alt_q  <= 1'b1;
		end else if (tick) begin
			alt_q  <= ~alt_q; // R16
			if (!mark) ones_q <= 2'h0;
			else if (ones_q != 2'(LITX_ONES_RUN - 1)) ones_q <= ones_q + 2'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_line_pos <= 1'b0;
			tx_line_neg <= 1'b0;
			last_pol_q  <= 1'b0;
			viol_done   <= 1'b0;
			line_oe     <= 1'b0;
		end else begin
			viol_done <= tick && use_viol;
			// Drive enable held high after reset in every mode; open drain is only flagged by litx_top
			line_oe   <= 1'b1;
			if (tick) begin
				if (sq_mode) begin
					tx_line_pos <= alt_q; // R09
					tx_line_neg <= ~alt_q;
				end else if (mark) begin
					// Violation repeats previous polarity
					tx_line_pos <= use_viol ? last_pol_q : ~last_pol_q;
					tx_line_neg <= use_viol ? ~last_pol_q : last_pol_q;
					if (!use_viol) last_pol_q <= ~last_pol_q;
				end else begin
					tx_line_pos <= 1'b0;
					tx_line_neg <= 1'b0;
				end
			end
		end
	end

	a_viol_one_shot: assert property (@(posedge core_clk) disable iff (!rst_b)
		viol_done |=> !viol_done) else $error("violation pulse repeated"); // R13
endmodule // litx_line_driver

// ==== core/litx_pkg.sv ====
// Package of register map, field positions and reset values for the line interface tx control
package litx_pkg;
	localparam logic [7:0] LITX_OFF_CTRL_ONE   = 8'h78;
	localparam logic [7:0] LITX_OFF_CTRL_TWO   = 8'h79;
	localparam logic [7:0] LITX_OFF_CTRL_THREE = 8'h7a;
	localparam logic [7:0] LITX_OFF_GAIN       = 8'h7d;
	localparam logic [7:0] LITX_RST_VAL        = 8'h00;
	// Gain register fields
	localparam int LITX_GAIN_LSB   = 0;
	localparam int LITX_GAIN_W     = 6;
	localparam int LITX_AGC_DIS    = 6;
	// Control one fields
	localparam int LITX_LBO_LSB    = 5;
	localparam int LITX_LBO_W      = 3;
	// Control two fields
	localparam int LITX_CUST_DRV   = 0;
	localparam int LITX_CUR_LIM    = 1;
	localparam int LITX_JA_SRC     = 3;
	localparam int LITX_TX_EN      = 4;
	localparam int LITX_VIOL       = 5;
	localparam int LITX_LRST       = 6;
	localparam int LITX_STD        = 7;
	// Control three fields
	localparam int LITX_ALT_PAT    = 0;
	// Run of ones at which an armed violation is sent
	localparam int LITX_ONES_RUN   = 3;
	localparam logic [2:0] LITX_LBO_SHORT = 3'h0;
	typedef enum logic [1:0] {
		LITX_TX_IDLE  = 2'b00,
		LITX_TX_ARMED = 2'b01
	} litx_viol_e;
endpackage

// ==== core/litx_sync2.sv ====
// Two flip-flop synchroniser for a pin level
`timescale 1ns/10ps
module litx_sync2 import litx_pkg::*; (
	input  wire logic core_clk, // Clock
	input  wire logic rst_b,    // Reset, active low
	input  wire logic d,        // Async level
	output logic      q         // Synchronised level
);
	logic meta_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // litx_sync2

// ==== core/litx_top.sv ====
// Line interface transmit control register bank and line driver top
// Functional notes
// R01: AGC on when disable bit is 0; gain code used only when 1.
// R02: Gain register: code bits 0-5, AGC disable bit 6.
// R03: Software loads gain from recommended set by mode, match, build-out.
// R04: Software writes zero to gain bit 7 and control-two bit 2.
// R05: T1 with AGC: shape adjust one 0Ah for codes 1,2,4, else 00h.
// R06: T1 without AGC: both shape adjust registers 00h.
// R07: In T1 the build-out code selects the transmit waveform.
// R08: High return loss build-out needs termination select bits zero.
// R09: Custom driver: square wave at code 0, open-drain otherwise.
// R10: Current limit disable bit: 0 enables limiter, 1 disables it.
// R11: Jitter clock from master clock at 0, from PLL at 1.
// R12: Transmit enable 0 sends all ones on jitter clock; 1 sends data.
// R13: Rising violation bit inserts one violation at next three ones.
// R14: Rising line reset bit resets recovery and recenters attenuator.
// R15: Line standard bit: 0 is T1, 1 is E1.
// R16: Alternating bit sends 1010 pattern on transmit clock.
// R17: Build-out code sits in bits 7 to 5 of control one.
// R18: Registers read back writes; edge bits act on 0-to-1 change.
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
module litx_top import litx_pkg::*; (
	input  wire logic       core_clk,          // 25 MHz clock
	input  wire logic       rst_b,             // Async reset, active low
	input  wire logic [7:0] reg_addr,          // Register address
	input  wire logic [7:0] reg_wdata,         // Write data
	input  wire logic       reg_wr,            // Write strobe
	input  wire logic       reg_rd,            // Read strobe
	output logic      [7:0] reg_rdata,         // Read data, cycle after strobe
	input  wire logic       transmit_clock,    // Line bit clock pin
	input  wire logic       jitter_clock,      // Jitter attenuator clock pin
	input  wire logic       tx_data,           // Data bit to send
	output logic            tx_line_pos,       // Positive line output
	output logic            tx_line_neg,       // Negative line output
	output logic            tx_line_oe,        // Line output enable
	output logic            tx_line_open_drain,// Open-drain drive mode
	output logic            agc_enable,        // Transmit AGC active
	output logic      [5:0] gain_level,        // Manual gain level
	output logic      [2:0] build_out_code,    // Waveform select
	output logic            e1_mode,           // Line standard
	output logic            cur_limit_en,      // Current limiter on
	output logic            ja_clk_from_pll,   // Jitter clock source
	output logic            line_reset_pulse,  // Recovery reset pulse
	output logic            viol_sent          // Violation sent pulse
);
	logic [7:0] ctrl_one_q;
	logic [7:0] ctrl_two_q;
	logic [7:0] ctrl_three_q;
	logic [7:0] gain_q;
	logic       viol_req_q;
	logic       transmit_clock_s;
	logic       jclk_s;
	logic       transmit_clock_d1_q;
	logic       jclk_d1_q;
	logic       drv_pos;
	logic       drv_neg;
	logic       drv_oe;
	logic       drv_done;
	litx_cfg_if cfg ();

	function automatic logic rise(input logic old_v, input logic new_v);
		return !old_v && new_v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_one_q   <= LITX_RST_VAL;
			ctrl_two_q   <= LITX_RST_VAL;
			ctrl_three_q <= LITX_RST_VAL;
			gain_q       <= LITX_RST_VAL;
		end else if (reg_wr) begin
			case (reg_addr)
				LITX_OFF_CTRL_ONE:   ctrl_one_q   <= reg_wdata; // R17
				LITX_OFF_CTRL_TWO:   ctrl_two_q   <= reg_wdata; // R18
				LITX_OFF_CTRL_THREE: ctrl_three_q <= reg_wdata;
				LITX_OFF_GAIN:       gain_q       <= reg_wdata; // R02
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				LITX_OFF_CTRL_ONE:   reg_rdata <= ctrl_one_q; // R18
				LITX_OFF_CTRL_TWO:   reg_rdata <= ctrl_two_q;
				LITX_OFF_CTRL_THREE: reg_rdata <= ctrl_three_q;
				LITX_OFF_GAIN:       reg_rdata <= gain_q;
				default:             reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Edge-triggered control bits
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			viol_req_q       <= 1'b0;
			line_reset_pulse <= 1'b0;
		end else begin
			viol_req_q <= reg_wr && (reg_addr == LITX_OFF_CTRL_TWO) &&
			              rise(ctrl_two_q[LITX_VIOL], reg_wdata[LITX_VIOL]); // R13
			line_reset_pulse <= reg_wr && (reg_addr == LITX_OFF_CTRL_TWO) &&
			              rise(ctrl_two_q[LITX_LRST], reg_wdata[LITX_LRST]); // R14
		end
	end

	////////////////////////////////////////////////////////////////////////
	litx_sync2 u_transmit_clock_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.d        (transmit_clock),
		.q        (transmit_clock_s)
	);

	litx_sync2 u_jclk_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.d        (jitter_clock),
		.q        (jclk_s)
	);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			transmit_clock_d1_q <= 1'b0;
			jclk_d1_q <= 1'b0;
		end else begin
			transmit_clock_d1_q <= transmit_clock_s;
			jclk_d1_q <= jclk_s;
		end
	end

	assign cfg.agc_off              = gain_q[LITX_AGC_DIS];
	assign cfg.gain_code            = gain_q[LITX_GAIN_LSB +: LITX_GAIN_W];
	assign cfg.build_out_code       = ctrl_one_q[LITX_LBO_LSB +: LITX_LBO_W];
	assign cfg.custom_driver_select = ctrl_two_q[LITX_CUST_DRV];
	assign cfg.tx_data_enable       = ctrl_two_q[LITX_TX_EN];
	assign cfg.alternating_pattern  = ctrl_three_q[LITX_ALT_PAT];
	assign cfg.viol_req             = viol_req_q;

	litx_line_driver u_drv (
		.core_clk    (core_clk),
		.rst_b       (rst_b),
		.cfg         (cfg),
		.bit_tick    (rise(transmit_clock_d1_q, transmit_clock_s)),
		.ja_tick     (rise(jclk_d1_q, jclk_s)),
		.tx_data     (tx_data),
		.tx_line_pos (drv_pos),
		.tx_line_neg (drv_neg),
		.line_oe     (drv_oe),
		.viol_done   (drv_done)
	);

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_line_pos        <= 1'b0;
			tx_line_neg        <= 1'b0;
			tx_line_oe         <= 1'b0;
			tx_line_open_drain <= 1'b0;
			viol_sent          <= 1'b0;
		end else begin
			tx_line_pos        <= drv_pos;
			tx_line_neg        <= drv_neg;
			tx_line_oe         <= drv_oe;
			tx_line_open_drain <= cfg.custom_driver_select &&
			                      (cfg.build_out_code != LITX_LBO_SHORT); // R09
			viol_sent          <= drv_done;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			agc_enable      <= 1'b1;
			gain_level      <= 6'h00;
			build_out_code  <= 3'h0;
			e1_mode         <= 1'b0;
			cur_limit_en    <= 1'b1;
			ja_clk_from_pll <= 1'b0;
		end else begin
			agc_enable      <= !cfg.agc_off; // R01
			gain_level      <= cfg.agc_off ? cfg.gain_code : 6'h00; // R01
			build_out_code  <= cfg.build_out_code; // R07
			e1_mode         <= ctrl_two_q[LITX_STD]; // R15
			cur_limit_en    <= !ctrl_two_q[LITX_CUR_LIM]; // R10
			ja_clk_from_pll <= ctrl_two_q[LITX_JA_SRC]; // R11
		end
	end

	////////////////////////////////////////////////////////////////////////
	a_read_back: assert property (@(posedge core_clk) disable iff (!rst_b)
		reg_wr && reg_addr == LITX_OFF_GAIN ##1 reg_rd && reg_addr == LITX_OFF_GAIN
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("gain readback wrong"); // R18
	a_gain_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
		!gain_q[LITX_AGC_DIS] |=> agc_enable && gain_level == 6'h00)
		else $error("gain leaks with agc on"); // R01
	a_gain_manual: assert property (@(posedge core_clk) disable iff (!rst_b)
		gain_q[LITX_AGC_DIS] |=> gain_level == $past(gain_q[5:0]))
		else $error("manual gain wrong"); // R02
	a_lrst_edge: assert property (@(posedge core_clk) disable iff (!rst_b)
		line_reset_pulse |=> !line_reset_pulse) else $error("reset pulse long"); // R14
	a_lrst_cause: assert property (@(posedge core_clk) disable iff (!rst_b)
		line_reset_pulse |-> $past(reg_wr) && !$past(ctrl_two_q[LITX_LRST]))
		else $error("reset pulse without rise"); // R14
	a_std_sel: assert property (@(posedge core_clk) disable iff (!rst_b)
		##1 e1_mode == $past(ctrl_two_q[LITX_STD])) else $error("std select"); // R15
	a_cur_lim: assert property (@(posedge core_clk) disable iff (!rst_b)
		##1 cur_limit_en == !$past(ctrl_two_q[LITX_CUR_LIM])) else $error("limiter"); // R10
	a_ja_src: assert property (@(posedge core_clk) disable iff (!rst_b)
		##1 ja_clk_from_pll == $past(ctrl_two_q[LITX_JA_SRC])) else $error("ja src"); // R11
	a_viol_cause: assert property (@(posedge core_clk) disable iff (!rst_b)
		viol_req_q |-> $past(reg_wdata[LITX_VIOL]) && !$past(ctrl_two_q[LITX_VIOL]))
		else $error("violation request without rise"); // R13
	a_open_drain: assert property (@(posedge core_clk) disable iff (!rst_b)
		ctrl_two_q[LITX_CUST_DRV] && ctrl_one_q[7:5] != 3'h0 |=> tx_line_open_drain)
		else $error("open drain missing"); // R09
	c_viol: cover property (@(posedge core_clk) viol_sent);
	c_lrst: cover property (@(posedge core_clk) line_reset_pulse);
	c_data: cover property (@(posedge core_clk) ctrl_two_q[LITX_TX_EN] && tx_line_pos);
endmodule // litx_top
